// File: lse_top.v
// Purpose: Ladder scan engine: cyclic input refresh, ladder, output refresh.
// Assumes: APB slave, 100 MHz clock, judgements valid at measurement start.
// Notes:   Two ladders of 20 rungs; scan ladder drives outputs and aux,
//          measurement ladder writes aux relays only.
// Contract
// - At power-on all eight output terminals are OFF before scanning.
// - At power-on every relay memory bit is cleared.
// - Scan repeats: input refresh, ladder evaluation, output refresh.
// - Input refresh copies eight input terminals into input relays.
// - Scan ladder reads input, output and auxiliary relays.
// - Output refresh drives terminals from output relays just evaluated.
// - One scan lasts between 0.3 and 3.0 ms.
// - Measurement start triggers judgement capture then measurement ladder evaluation.
// - Judgement OK enters ladder as 1, fail as 0.
// - Measurement ladder coils write aux relays read by scan ladder. Here only aux indices below 110 are written; 110 to 127 are skipped.
// - There are 128 auxiliary relay bits, indices 0 to 127.
// - Normally-open contact conducts when its source is 1.
// - Normally-closed contact blocks when its source is 1.
// - Branch symbols join contact paths as a logical OR.
// - Each ladder has 20 rungs of eight contacts and one coil.
// - A coil is only accepted on a rung holding a contact.
// - Deleting the sole column-0 contact removes coil; shift or blank delete. Here only shift delete does; blank delete skips column 0.
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "lse_regs.vh"
module lse_top #(
	parameter [15:0] SCAN_MIN_CYC = `LSE_SCAN_MIN_CYC
) (
	input  wire        CLK_I,
	input  wire        NRST_I,
	input  wire        PSEL_I,
	input  wire        PENABLE_I,
	input  wire        PWRITE_I,
	input  wire [11:0] PADDR_I,
	input  wire [31:0] PWDATA_I,
	output reg  [31:0] PRDATA_O,
	output reg         PREADY_O,
	output reg         PSLVERR_O,
	input  wire [7:0]  PAR_IN_I,
	input  wire        MEAS_START_I,
	input  wire [15:0] JUDGE_I,
	output reg  [7:0]  PAR_OUT_O,
	output reg         SCAN_TICK_O
);
	// Program store
	reg [`LSE_CT_W-1:0]           cont_q [0:`LSE_NCONT-1];
	reg [`LSE_CL_W-1:0]           coil_q [0:`LSE_NCOIL-1];
	// Relay memories
	reg [7:0]                     in_rel_q;
	reg [7:0]                     out_rel_q;
	reg [`LSE_NAUX-1:0]           aux_q;
	reg [`LSE_NJUDGE-1:0]         judge_q;
	// Control and sequencing
	reg                           run_q;
	reg [`LSE_PA_W-1:0]           pa_q;
	reg [2:0]                     state_q;
	reg [4:0]                     rung_q;
	reg [15:0]                    per_q;
	reg                           meas_pend_q;
	reg                           meas_start_q;
	reg [15:0]                    scan_cnt_q;
	reg [15:0]                    meas_cnt_q;
	// Synchronised pins
	wire [7:0]                    par_in_s;
	wire                          meas_s;
	wire [`LSE_NJUDGE-1:0]        judge_s;
	// Evaluation datapath
	reg  [`LSE_COLS*`LSE_CT_W-1:0] ev_cont;
	reg  [`LSE_COLS*`LSE_CT_W-1:0] pa_cont;
	wire [`LSE_SRC_W-1:0]          src_map;
	wire                           ev_res;
	wire                           ev_any;
	wire                           pa_any;
	wire                           ev_meas;
	wire [`LSE_CL_W-1:0]           ev_coil;
	wire                           meas_rise;
	// APB decode
	wire                           apb_setup;
	wire                           apb_wr;
	reg  [31:0]                    rd_d;
	reg                            err_d;
	wire                           coil_ok;
	integer                        k;
	integer                        m;

	// Contact index: ladder, rung and column into the flat store
	function [8:0] lse_cidx;
		input       ladder;
		input [4:0] rung;
		input [2:0] col;
		begin
			lse_cidx = (ladder ? `LSE_CT_LADDER_BASE : 9'h000) +
				{1'b0, rung, 3'h0} + {6'h00, col};
		end
	endfunction

	// Coil index: ladder and rung into the coil store
	function [5:0] lse_lidx;
		input       ladder;
		input [4:0] rung;
		begin
			lse_lidx = (ladder ? `LSE_CL_LADDER_BASE : 6'h00) + {1'b0, rung};
		end
	endfunction

	// Pins cross into the clock domain through three stages
	lse_sync #(.W(8)) u_sync_in (
		.clk_i  (CLK_I),
		.nrst_i (NRST_I),
		.d_i    (PAR_IN_I),
		.q_o    (par_in_s)
	);

	lse_sync #(.W(17)) u_sync_meas (
		.clk_i  (CLK_I),
		.nrst_i (NRST_I),
		.d_i    ({MEAS_START_I, JUDGE_I}),
		.q_o    ({meas_s, judge_s})
	);

	assign meas_rise = meas_s & ~meas_start_q;
	assign ev_meas   = (state_q == `LSE_ST_MEVAL);
	assign ev_coil   = coil_q[lse_lidx(ev_meas, rung_q)];

	// source map: inputs, outputs, judgements, aux relays
	assign src_map = {aux_q, 96'h0, judge_q, out_rel_q, in_rel_q};

	// Gather the rung under evaluation and the rung under edit
	always @* begin
		ev_cont = {`LSE_COLS*`LSE_CT_W{1'b0}};
		pa_cont = {`LSE_COLS*`LSE_CT_W{1'b0}};
		for (k = 0; k < `LSE_COLS; k = k + 1) begin
			ev_cont[k*`LSE_CT_W +: `LSE_CT_W] = cont_q[lse_cidx(ev_meas, rung_q, k[2:0])];
			pa_cont[k*`LSE_CT_W +: `LSE_CT_W] =
				cont_q[lse_cidx(pa_q[`LSE_PA_LADDER], pa_q[`LSE_PA_RUNG], k[2:0])];
		end
	end

	lse_rung u_rung_ev (
		.cont_i   (ev_cont),
		.src_i    (src_map),
		.result_o (ev_res),
		.any_o    (ev_any)
	);

	lse_rung u_rung_pa (
		.cont_i   (pa_cont),
		.src_i    (src_map),
		.result_o (),
		.any_o    (pa_any)
	);

	// APB phases; one wait-free access cycle after setup
	assign apb_setup = PSEL_I & ~PENABLE_I;
	assign apb_wr    = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I & ~PSLVERR_O;
	// coil accepted only on a rung with a contact
	assign coil_ok   = pa_any;

	// Read data and error decided in the setup phase
	always @* begin
		rd_d  = 32'h0000_0000;
		err_d = 1'b0;
		case (PADDR_I)
			`LSE_OFF_CTRL:   rd_d = {31'h0, run_q};
			`LSE_OFF_STATUS: rd_d = {scan_cnt_q, meas_cnt_q[10:0], ev_meas, meas_pend_q, state_q};
			`LSE_OFF_PADDR:  rd_d = {22'h0, pa_q};
			`LSE_OFF_PDATA: begin
				if (pa_q[`LSE_PA_COIL])
					rd_d = {23'h0, coil_q[lse_lidx(pa_q[`LSE_PA_LADDER], pa_q[`LSE_PA_RUNG])]};
				else
					rd_d = {21'h0, cont_q[lse_cidx(pa_q[`LSE_PA_LADDER],
						pa_q[`LSE_PA_RUNG], pa_q[`LSE_PA_COL])]};
				// Writes of a coil to an empty rung are refused
				if (PWRITE_I && pa_q[`LSE_PA_COIL] && PWDATA_I[`LSE_CL_USED] && !coil_ok)
					err_d = 1'b1;
				if (pa_q[`LSE_PA_RUNG] > `LSE_LAST_RUNG)
					err_d = 1'b1;
			end
			`LSE_OFF_CMD:    rd_d = 32'h0000_0000;
			`LSE_OFF_INREL:  rd_d = {24'h0, in_rel_q};
			`LSE_OFF_OUTREL: rd_d = {24'h0, out_rel_q};
			`LSE_OFF_JUDGE:  rd_d = {16'h0, judge_q};
			`LSE_OFF_AUX0:   rd_d = aux_q[31:0];
			`LSE_OFF_AUX1:   rd_d = aux_q[63:32];
			`LSE_OFF_AUX2:   rd_d = aux_q[95:64];
			`LSE_OFF_AUX3:   rd_d = aux_q[127:96];
			default:         err_d = 1'b1;
		endcase
	end

	// APB answer registers
	always @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			PRDATA_O  <= 32'h0000_0000;
			PREADY_O  <= 1'b0;
			PSLVERR_O <= 1'b0;
		end else begin
			PREADY_O  <= apb_setup;
			if (apb_setup) begin
				PRDATA_O  <= PWRITE_I ? 32'h0000_0000 : rd_d;
				PSLVERR_O <= err_d;
			end else begin
				PSLVERR_O <= 1'b0;
			end
		end
	end

	// Control registers written by software
	always @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			run_q <= 1'b0;
			pa_q  <= {`LSE_PA_W{1'b0}};
		end else if (apb_wr) begin
			if (PADDR_I == `LSE_OFF_CTRL)
				run_q <= PWDATA_I[`LSE_CTRL_RUN];
			if (PADDR_I == `LSE_OFF_PADDR)
				pa_q <= PWDATA_I[`LSE_PA_W-1:0];
		end
	end

	// Program store: direct writes and the two delete commands
	always @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			for (m = 0; m < `LSE_NCONT; m = m + 1)
				cont_q[m] <= {`LSE_CT_W{1'b0}};
			for (m = 0; m < `LSE_NCOIL; m = m + 1)
				coil_q[m] <= {`LSE_CL_W{1'b0}};
		end else if (apb_wr && PADDR_I == `LSE_OFF_PDATA) begin
			if (pa_q[`LSE_PA_COIL])
				coil_q[lse_lidx(pa_q[`LSE_PA_LADDER], pa_q[`LSE_PA_RUNG])] <=
					PWDATA_I[`LSE_CL_W-1:0];
			else
				cont_q[lse_cidx(pa_q[`LSE_PA_LADDER], pa_q[`LSE_PA_RUNG],
					pa_q[`LSE_PA_COL])] <= PWDATA_I[`LSE_CT_W-1:0];
		end else if (apb_wr && PADDR_I == `LSE_OFF_CMD) begin
			// shifting delete pulls later contacts forward
			if (PWDATA_I[1:0] == `LSE_CMD_SHIFT_ERASE) begin
				for (m = 0; m < `LSE_COLS - 1; m = m + 1) begin
					if (m >= pa_q[`LSE_PA_COL])
						cont_q[lse_cidx(pa_q[`LSE_PA_LADDER], pa_q[`LSE_PA_RUNG], m[2:0])] <=
							cont_q[lse_cidx(pa_q[`LSE_PA_LADDER], pa_q[`LSE_PA_RUNG],
								m[2:0] + 3'h1)];
				end
				cont_q[lse_cidx(pa_q[`LSE_PA_LADDER], pa_q[`LSE_PA_RUNG], `LSE_LAST_COL)] <=
					{`LSE_CT_W{1'b0}};
			end
			// blanking delete leaves later contacts, never column 0
			if (PWDATA_I[1:0] == `LSE_CMD_BLANK_ERASE && pa_q[`LSE_PA_COL] != 3'h0)
				cont_q[lse_cidx(pa_q[`LSE_PA_LADDER], pa_q[`LSE_PA_RUNG],
					pa_q[`LSE_PA_COL])] <= {`LSE_CT_W{1'b0}};
			// sole column-0 contact deleted takes the coil with it
			if (PWDATA_I[1:0] == `LSE_CMD_SHIFT_ERASE && pa_q[`LSE_PA_COL] == 3'h0 &&
				pa_cont[`LSE_CT_USED] &&
				pa_cont[`LSE_COLS*`LSE_CT_W-1:`LSE_CT_W] ==
					{(`LSE_COLS-1)*`LSE_CT_W{1'b0}})
				coil_q[lse_lidx(pa_q[`LSE_PA_LADDER], pa_q[`LSE_PA_RUNG])] <=
					{`LSE_CL_W{1'b0}};
		end
	end

	// Scan sequencer and relay memories
	always @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			PAR_OUT_O    <= 8'h00;
			SCAN_TICK_O  <= 1'b0;
			in_rel_q     <= 8'h00;
			out_rel_q    <= 8'h00;
			aux_q        <= {`LSE_NAUX{1'b0}};
			judge_q      <= {`LSE_NJUDGE{1'b0}};
			state_q      <= `LSE_ST_IDLE;
			rung_q       <= 5'h00;
			per_q        <= 16'h0000;
			meas_pend_q  <= 1'b0;
			meas_start_q <= 1'b0;
			scan_cnt_q   <= 16'h0000;
			meas_cnt_q   <= 16'h0000;
		end else begin
			meas_start_q <= meas_s;
			SCAN_TICK_O  <= 1'b0;
			per_q        <= per_q + 16'h0001;
			if (meas_rise) begin
				judge_q     <= judge_s;
				meas_pend_q <= 1'b1;
			end
			case (state_q)
				`LSE_ST_IDLE: begin
					per_q <= 16'h0000;
					if (run_q)
						state_q <= `LSE_ST_INREF;
				end
				`LSE_ST_INREF: begin
					in_rel_q <= par_in_s;
					rung_q   <= 5'h00;
					state_q  <= `LSE_ST_EVAL;
				end
				// scan or measurement ladder, one rung per cycle
				`LSE_ST_EVAL, `LSE_ST_MEVAL: begin
					if (ev_any && ev_coil[`LSE_CL_USED]) begin
						if (!ev_meas && ev_coil[`LSE_CL_OUT])
							out_rel_q[ev_coil[2:0]] <= ev_res;
						else if (!ev_meas || ev_coil[`LSE_CL_IDX] < `LSE_SPECIAL_LO)
							aux_q[ev_coil[`LSE_CL_IDX]] <= ev_res;
					end
					rung_q <= rung_q + 5'h01;
					if (rung_q == `LSE_LAST_RUNG) begin
						rung_q  <= 5'h00;
						state_q <= ev_meas ? `LSE_ST_WAIT : `LSE_ST_OUTREF;
					end
				end
				// output refresh from relays just evaluated
				`LSE_ST_OUTREF: begin
					PAR_OUT_O   <= out_rel_q;
					SCAN_TICK_O <= 1'b1;
					scan_cnt_q  <= scan_cnt_q + 16'h0001;
					if (meas_pend_q && !meas_rise) begin
						meas_pend_q <= 1'b0;
						meas_cnt_q  <= meas_cnt_q + 16'h0001;
						state_q     <= `LSE_ST_MEVAL;
					end else begin
						state_q <= `LSE_ST_WAIT;
					end
				end
				// pad scan to the minimum period
				`LSE_ST_WAIT: begin
					if (per_q >= SCAN_MIN_CYC - 16'h0001) begin
						per_q   <= 16'h0000;
						state_q <= run_q ? `LSE_ST_INREF : `LSE_ST_IDLE;
					end
				end
				default: state_q <= `LSE_ST_IDLE;
			endcase
		end
	end
endmodule // lse_top
`default_nettype wire

// File: lse_regs.vh
// Purpose: Constants for the ladder scan engine: APB map, fields, timing.
// Assumes: 32-bit APB data, one aligned word per register.
// Notes:   Included by the top and rung design files; the synchroniser does not include it.
`ifndef LSE_REGS_VH
`define LSE_REGS_VH

// Register byte offsets
`define LSE_OFF_CTRL      12'h000
`define LSE_OFF_STATUS    12'h004
`define LSE_OFF_PADDR     12'h008
`define LSE_OFF_PDATA     12'h00C
`define LSE_OFF_CMD       12'h010
`define LSE_OFF_INREL     12'h014
`define LSE_OFF_OUTREL    12'h018
`define LSE_OFF_JUDGE     12'h01C
`define LSE_OFF_AUX0      12'h020
`define LSE_OFF_AUX1      12'h024
`define LSE_OFF_AUX2      12'h028
`define LSE_OFF_AUX3      12'h02C

// CTRL fields
`define LSE_CTRL_RUN      0
// CMD codes (write to CMD with program address set)
`define LSE_CMD_SHIFT_ERASE 2'h1
`define LSE_CMD_BLANK_ERASE 2'h2

// Program address fields
`define LSE_PA_RUNG       4:0
`define LSE_PA_COL        7:5
`define LSE_PA_COIL       8
`define LSE_PA_LADDER     9
`define LSE_PA_W          10

// Contact word: source, normally-closed, starts new OR branch, present
`define LSE_CT_W          11
`define LSE_CT_SRC        7:0
`define LSE_CT_NC         8
`define LSE_CT_BR         9
`define LSE_CT_USED       10
// Coil word: index, drives an output relay, present
`define LSE_CL_W          9
`define LSE_CL_IDX        6:0
`define LSE_CL_OUT        7
`define LSE_CL_USED       8

// Ladder geometry
`define LSE_RUNGS         20
`define LSE_COLS          8
`define LSE_LAST_RUNG     5'h13
`define LSE_LAST_COL      3'h7
`define LSE_NCONT         320
`define LSE_NCOIL         40
`define LSE_NAUX          128
`define LSE_SPECIAL_LO    7'h6E
`define LSE_NJUDGE        16
// Store offsets of the measurement ladder behind the scan ladder
`define LSE_CT_LADDER_BASE 9'h0A0
`define LSE_CL_LADDER_BASE 6'h14

// Contact source index space
`define LSE_SRC_W         256

// Scan timing
`define LSE_CLK_NS        10
`define LSE_SCAN_MIN_NS   300000
`define LSE_SCAN_MAX_NS   3000000
`define LSE_SCAN_MIN_CYC  16'h7530 // 0.3 ms in 10 ns cycles, sized for the period counter

// Scan states
`define LSE_ST_IDLE       3'h0
`define LSE_ST_INREF      3'h1
`define LSE_ST_EVAL       3'h2
`define LSE_ST_OUTREF     3'h3
`define LSE_ST_MEVAL      3'h4
`define LSE_ST_WAIT       3'h5

`endif

// File: lse_sync.v
// Purpose: Three-stage synchroniser with agreement filter for pin inputs.
// Assumes: Inputs are asynchronous to CLK.
// Notes:   Output changes only when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module lse_sync #(
	parameter W = 8
) (
	input  wire         clk_i,
	input  wire         nrst_i,
	input  wire [W-1:0] d_i,
	output reg  [W-1:0] q_o
);
	reg [W-1:0] s1_q;
	reg [W-1:0] s2_q;
	reg [W-1:0] s3_q;
	integer     i;

	// First stage feeds only the second one
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s1_q <= {W{1'b0}};
			s2_q <= {W{1'b0}};
			s3_q <= {W{1'b0}};
			q_o  <= {W{1'b0}};
		end else begin
			s1_q <= d_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (i = 0; i < W; i = i + 1) begin
				if (s2_q[i] == s3_q[i])
					q_o[i] <= s3_q[i];
			end
		end
	end
endmodule // lse_sync
`default_nettype wire

// File: lse_rung.v
// Purpose: Evaluate one ladder rung of eight contacts against a source map.
// Assumes: Contacts packed column 0 in the low bits.
// Notes:   Pure combinational; caller registers the result.
`timescale 1ns/1ps
`default_nettype none
`include "lse_regs.vh"
module lse_rung (
	input  wire [`LSE_COLS*`LSE_CT_W-1:0] cont_i,
	input  wire [`LSE_SRC_W-1:0]          src_i,
	output reg                            result_o,
	output reg                            any_o
);
	reg [`LSE_CT_W-1:0] ct;
	reg                 branch;
	reg                 branch_has;
	reg                 lvl;
	integer             c;

	// Branches OR together, contacts within a branch AND
	always @* begin
		ct         = {`LSE_CT_W{1'b0}};
		branch     = 1'b1;
		branch_has = 1'b0;
		result_o   = 1'b0;
		any_o      = 1'b0;
		lvl        = 1'b0;
		for (c = 0; c < `LSE_COLS; c = c + 1) begin
			ct = cont_i[c*`LSE_CT_W +: `LSE_CT_W];
			if (ct[`LSE_CT_USED]) begin
				if (ct[`LSE_CT_BR] && branch_has) begin
					result_o = result_o | branch;
					branch   = 1'b1;
				end
				lvl = src_i[ct[`LSE_CT_SRC]];
				if (ct[`LSE_CT_NC])
					lvl = ~lvl;
				branch     = branch & lvl;
				branch_has = 1'b1;
				any_o      = 1'b1;
			end
		end
		if (branch_has)
			result_o = result_o | branch;
	end
endmodule // lse_rung
`default_nettype wire

// File: lse_top_checker.sv
// Purpose: Port-level assertions for the ladder scan engine.
// Assumes: CTRL run bit stays set once scanning has begun.
// Notes:   Period figures follow the SCAN_MIN_CYC handed on by bind.
`timescale 1ns/1ps
`default_nettype none
module lse_top_checker #(
	parameter [15:0] SCAN_MIN_CYC = 16'h0040
) (
	input wire logic       CLK_I,
	input wire logic       NRST_I,
	input wire logic       PSEL_I,
	input wire logic       PENABLE_I,
	input wire logic       PREADY_O,
	input wire logic       PSLVERR_O,
	input wire logic [7:0] PAR_OUT_O,
	input wire logic       SCAN_TICK_O
);
	logic [15:0] gap_q;
	logic        seen_q;

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!NRST_I);

	// Cycles since last refresh; seen marks the first one
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			gap_q  <= 16'h0000;
			seen_q <= 1'b0;
		end else begin
			gap_q  <= SCAN_TICK_O ? 16'h0000 : gap_q + 16'h0001;
			seen_q <= seen_q | SCAN_TICK_O;
		end
	end

	a_outputs_off_first: assert property (!seen_q && !SCAN_TICK_O |-> PAR_OUT_O == 8'h00)
		else $error("outputs on before first refresh");
	a_tick_single: assert property (SCAN_TICK_O |=> !SCAN_TICK_O)
		else $error("refresh pulse too long");
	a_out_on_refresh: assert property (!$stable(PAR_OUT_O) |-> SCAN_TICK_O)
		else $error("outputs moved outside refresh");
	a_scan_period_exact: assert property (seen_q && SCAN_TICK_O |-> gap_q == SCAN_MIN_CYC - 16'h0001)
		else $error("scan period wrong");
	a_scan_not_stalled: assert property (seen_q |-> gap_q < SCAN_MIN_CYC)
		else $error("scan overran its period");
	a_ready_after_setup: assert property (PSEL_I && !PENABLE_I |=> PREADY_O) // bus handshake
		else $error("no ready in first access cycle");
	a_ready_single: assert property (PREADY_O |=> !PREADY_O) // bus handshake
		else $error("ready held too long");
	a_ready_in_access: assert property (PREADY_O |-> PSEL_I && PENABLE_I) // bus handshake
		else $error("ready outside access");
	a_error_with_ready: assert property (PSLVERR_O |-> PREADY_O) // bus handshake
		else $error("error without ready");

	// Main scenarios reached
	c_refresh: cover property (SCAN_TICK_O);
	c_bus_error: cover property (PSLVERR_O);
	c_aux_output: cover property ($rose(PAR_OUT_O[4]));
endmodule // lse_top_checker

bind lse_top lse_top_checker #(.SCAN_MIN_CYC(SCAN_MIN_CYC)) chk_u (.CLK_I(CLK_I),
	.NRST_I(NRST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PREADY_O(PREADY_O),
	.PSLVERR_O(PSLVERR_O), .PAR_OUT_O(PAR_OUT_O), .SCAN_TICK_O(SCAN_TICK_O));
`default_nettype wire

// File: lse_equip.sv
// Purpose: External equipment on the parallel terminals: switches and lamps.
// Assumes: Judgement lines settle before the start line rises.
// Notes:   Lamps latch the output terminals at each refresh pulse.
`timescale 1ns/1ps
`default_nettype none
module lse_equip (
	input wire logic        clk_i,
	input wire logic [7:0]  par_out_i,
	input wire logic        tick_i,
	output var logic [7:0]  par_in_o,
	output var logic        start_o,
	output var logic [15:0] judge_o,
	output var logic [7:0]  lamp_o
);
	// Idle equipment at power-up
	initial begin
		par_in_o = 8'h00;
		start_o  = 1'b0;
		judge_o  = 16'h0000;
		lamp_o   = 8'h00;
	end

	// Lamps follow terminals only when refreshed
	always @(posedge clk_i) begin
		if (tick_i) lamp_o <= par_out_i;
	end

	task set_in(input logic [7:0] v);
		@(posedge clk_i);
		par_in_o <= v;
	endtask

	task measure(input logic [15:0] j);
		@(posedge clk_i);
		judge_o <= j;
		repeat (4) @(posedge clk_i);
		start_o <= 1'b1;
		repeat (8) @(posedge clk_i);
		start_o <= 1'b0;
	endtask
endmodule // lse_equip
`default_nettype wire

// File: tb_ladder_scan_engine.sv
// Purpose: Self-checking bench for the ladder scan engine over APB.
// Assumes: Short scan period of 64 cycles set by parameter.
// Notes:   Program covers NO, NC, AND, OR, aux, deletes and measurement.
`timescale 1ns/1ps
`default_nettype none
module tb_ladder_scan_engine;
	logic        clk, rst_n, psel, penable, pwrite, start, tick, pready, pslverr, err, e2;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0]  pin, pout, lamp, v;
	logic [15:0] judge;
	int          fail_count = 0, checks = 0, cyc = 0;
	logic [9:0]  pa_t [22] = '{10'h000, 10'h100, 10'h001, 10'h101, 10'h002, 10'h022, 10'h102,
		10'h003, 10'h023, 10'h103, 10'h004, 10'h104, 10'h005, 10'h105, 10'h006, 10'h026,
		10'h106, 10'h007, 10'h027, 10'h107, 10'h200, 10'h300};
	logic [10:0] w_t [22] = '{11'h400, 11'h180, 11'h501, 11'h181, 11'h402, 11'h403, 11'h182,
		11'h404, 11'h605, 11'h183, 11'h485, 11'h184, 11'h400, 11'h185, 11'h401, 11'h400,
		11'h186, 11'h402, 11'h403, 11'h187, 11'h410, 11'h105};
	logic [7:0]  vals [4] = '{8'h00, 8'hFF, 8'h35, 8'h0A};

	lse_top #(.SCAN_MIN_CYC(16'h0040)) dut_u (.CLK_I(clk), .NRST_I(rst_n), .PSEL_I(psel),
		.PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .PAR_IN_I(pin),
		.MEAS_START_I(start), .JUDGE_I(judge), .PAR_OUT_O(pout), .SCAN_TICK_O(tick));
	lse_equip eq_u (.clk_i(clk), .par_out_i(pout), .tick_i(tick), .par_in_o(pin),
		.start_o(start), .judge_o(judge), .lamp_o(lamp));

	// Clock and hang guard
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc > 20000) begin
			fail_count++;
			results();
		end
	end

	task results;
		if (fail_count == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Request held until ready is sampled high
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task prog(input logic [9:0] pa, input logic [11:0] reg_a, input logic [10:0] w,
		input logic exp_err);
		apb(1'b1, 12'h008, {22'h0, pa});
		e2 = err;
		apb(1'b1, reg_a, {21'h0, w});
		chk({31'h0, e2 | err}, {31'h0, exp_err});
	endtask

	task ticks(input int n);
		repeat (n) begin
			@(posedge clk);
			while (tick !== 1'b1) @(posedge clk);
		end
		@(posedge clk);
	endtask

	function automatic logic [7:0] exp_out(input logic [7:0] x, input logic a5);
		return {x[2], x[0], 1'b0, a5, x[4] | x[5], x[2] & x[3], ~x[1], x[0]};
	endfunction

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		chk({24'h0, pout}, 32'h0);
		for (logic [11:0] a = 12'h014; a <= 12'h02C; a += 12'h004) begin
			apb(1'b0, a, 32'h0);
			chk(rd, 32'h0);
		end
		apb(1'b0, 12'h030, 32'h0);
		chk({31'h0, err}, 32'h1);
		prog(10'h108, 12'h00C, 11'h180, 1'b1);
		prog(10'h014, 12'h00C, 11'h400, 1'b1);
		prog(10'h0F3, 12'h00C, 11'h407, 1'b0);
		for (int i = 0; i < 22; i++) prog(pa_t[i], 12'h00C, w_t[i], 1'b0);
		// Delete: sole contact drops coil, shift moves up, blank leaves gap
		prog(10'h005, 12'h010, 11'h001, 1'b0);
		prog(10'h006, 12'h010, 11'h001, 1'b0);
		prog(10'h027, 12'h010, 11'h002, 1'b0);
		apb(1'b1, 12'h000, 32'h1);
		foreach (vals[i]) begin
			v = vals[i];
			eq_u.set_in(v);
			ticks(3);
			chk({24'h0, lamp}, {24'h0, exp_out(v, 1'b0)});
			apb(1'b0, 12'h014, 32'h0);
			chk(rd, {24'h0, v});
			apb(1'b0, 12'h018, 32'h0);
			chk(rd, {24'h0, exp_out(v, 1'b0)});
		end
		// measurement coil uses ordinary aux 5 only
		for (int j = 1; j >= 0; j--) begin
			eq_u.measure({15'h0, j[0]});
			ticks(3);
			chk({24'h0, lamp}, {24'h0, exp_out(v, j[0])});
			apb(1'b0, 12'h020, 32'h0);
			chk({31'h0, rd[5]}, {31'h0, j[0]});
			apb(1'b0, 12'h01C, 32'h0);
			chk(rd, {31'h0, j[0]});
		end
		results();
	end
endmodule // tb_ladder_scan_engine
`default_nettype wire
